/* File: test_trace_filter_and_pmi_freeze.sv */
// self-checking testbench for the trace filter and interrupt freeze block
`timescale 1ns/1ps
module test_trace_filter_and_pmi_freeze;
  import tfz_pkg::*;
  logic i_clk_sys;
  logic i_srst;
  logic i_ce;
  tfz_msr_req_s i_msr_req;
  tfz_evt_s i_evt;
  logic [1:0] i_cpl;
  logic [7:0] i_perf_version;
  tfz_msr_rsp_s o_msr_rsp;
  logic [31:0] o_leaf1_ecx;
  logic o_branch_record_en;
  logic o_trace_msg_en;
  logic o_trace_store_en;
  logic [NUM_GP-1:0] o_gp_count_en;
  logic [NUM_FX-1:0] o_fx_count_en;
  logic o_pmi_req;
  int err_count;
  int samples_checked;
  logic [63:0] m_dbg;
  logic [63:0] m_gctl;
  logic [63:0] m_fxctl;
  logic [63:0] m_stat;
  logic [63:0] m_evsel [NUM_GP];
  logic [7:0] vers [4] = '{8'h01, 8'h02, 8'h03, 8'h04};

  tfz_core DUT (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_ce(i_ce), .i_msr_req(i_msr_req),
    .i_evt(i_evt), .i_cpl(i_cpl), .i_perf_version(i_perf_version), .o_msr_rsp(o_msr_rsp),
    .o_leaf1_ecx(o_leaf1_ecx), .o_branch_record_en(o_branch_record_en),
    .o_trace_msg_en(o_trace_msg_en), .o_trace_store_en(o_trace_store_en),
    .o_gp_count_en(o_gp_count_en), .o_fx_count_en(o_fx_count_en), .o_pmi_req(o_pmi_req));

  initial
  begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end

  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // derived enables from the model
  task automatic check_outs();
    logic sup;
    sup = (i_cpl == 2'd0) ? m_dbg[DBG_OFF_PRIV_BIT] : m_dbg[DBG_OFF_USER_BIT];
    chk("record_en", 64'(o_branch_record_en), 64'(m_dbg[0] & ~m_stat[STAT_BR_FRZ_BIT]));
    chk("msg_en", 64'(o_trace_msg_en), 64'(m_dbg[DBG_MSG_BIT] & ~sup));
    chk("store_en", 64'(o_trace_store_en), 64'(m_dbg[DBG_STORE_BIT] & ~sup));
    chk("gp_en", 64'(o_gp_count_en), 64'(m_gctl[3:0] & ~{4{m_stat[STAT_COUNTER_FREEZE_FLAG_BIT]}}));
    chk("fx_en", 64'(o_fx_count_en), 64'(m_gctl[34:32] & ~{3{m_stat[STAT_COUNTER_FREEZE_FLAG_BIT]}}));
    chk("cap_word", 64'(o_leaf1_ecx), 64'h10);
  endtask

  // one register access, model updated alongside
  task automatic msr(input logic wr, input logic [31:0] addr, input logic [63:0] wdata);
    logic [63:0] er;
    logic ef;
    int idx;
    er = 64'h0;
    ef = 1'b0;
    idx = int'(addr - MSR_EVTSEL_BASE);
    i_msr_req = '{wr: wr, rd: ~wr, addr: addr, wdata: wdata};
    @(posedge i_clk_sys);
    #1;
    i_msr_req = '0;
    case (addr)
      MSR_STATUS: if (wr) ef = 1'b1; else er = m_stat;
      MSR_OVF_CLR: if (wr) m_stat = m_stat & ~wdata;
      MSR_DBGCTL: if (wr) m_dbg = wdata & DBG_WMASK; else er = m_dbg;
      MSR_GCTL: if (wr) m_gctl = wdata & GCTL_MASK; else er = m_gctl;
      MSR_FXCTL: if (wr) m_fxctl = wdata & FXCTL_MASK; else er = m_fxctl;
      default:
        if (idx >= 0 && idx < NUM_GP)
        begin
          if (wr) m_evsel[idx] = wdata; else er = m_evsel[idx];
        end
        else
          ef = 1'b1;
    endcase
    chk("ack", 64'(o_msr_rsp.ack), 64'h1);
    chk("fault", 64'(o_msr_rsp.fault), 64'(ef));
    if (!wr || ef)
      chk("rdata", o_msr_rsp.rdata, er);
    check_outs();
    // idle cycle so the next request starts in a fresh time step
    @(posedge i_clk_sys);
    #1;
  endtask

  // one event cycle, then status readback
  task automatic fire(input tfz_evt_s e);
    logic cond;
    cond = e.precise_sample_buffer_thresh | e.bts_thresh;
    for (int i = 0; i < NUM_GP; i++)
      cond = cond | (e.gp_ovf[i] & m_evsel[i][EVT_PMI_BIT]);
    for (int j = 0; j < NUM_FX; j++)
      cond = cond | (e.fx_ovf[j] & m_fxctl[j*FX_FIELD_W+FX_PMI_BIT]);
    i_evt = e;
    @(posedge i_clk_sys);
    #1;
    i_evt = '0;
    chk("intr_req", 64'(o_pmi_req), 64'(cond));
    m_stat = m_stat | {1'b0, e.precise_sample_buffer_thresh, e.bts_thresh, 26'h0, e.fx_ovf, 28'h0, e.gp_ovf};
    if (cond && i_perf_version >= VER_FREEZE_MIN)
    begin
      if (i_perf_version < VER_STREAM_MIN)
      begin
        if (m_dbg[DBG_FRZ_BR_BIT]) m_dbg[DBG_REC_BIT] = 1'b0;
        if (m_dbg[DBG_FRZ_CTR_BIT]) m_gctl = 64'h0;
      end
      else
      begin
        m_stat[STAT_BR_FRZ_BIT] = m_stat[STAT_BR_FRZ_BIT] | m_dbg[DBG_FRZ_BR_BIT];
        m_stat[STAT_COUNTER_FREEZE_FLAG_BIT] = m_stat[STAT_COUNTER_FREEZE_FLAG_BIT] | m_dbg[DBG_FRZ_CTR_BIT];
      end
    end
    check_outs();
    msr(1'b0, MSR_STATUS, 64'h0);
    chk("intr_low", 64'(o_pmi_req), 64'h0);
  endtask

  initial
  begin
    repeat (100000) @(posedge i_clk_sys);
    err_count++;
    print_verdict();
  end

  initial
  begin
    err_count = 0;
    samples_checked = 0;
    i_srst = 1'b1;
    i_ce = 1'b1;
    i_msr_req = '0;
    i_evt = '0;
    i_cpl = 2'd0;
    i_perf_version = 8'h04;
    {m_dbg, m_gctl, m_fxctl, m_stat} = '0;
    foreach (m_evsel[i]) m_evsel[i] = 64'h0;
    void'($urandom(32'hf6e6));
    repeat (10) @(posedge i_clk_sys);
    #1;
    i_srst = 1'b0;
    @(posedge i_clk_sys);
    #1;
    for (int a = 0; a < 8; a++)
      msr(1'b0, MSR_DBGCTL + 32'(a), 64'h0);
    msr(1'b0, MSR_STATUS, 64'h0);
    $display("test reset done");
    for (int a = 0; a < 8; a++)
      msr(1'b1, MSR_DBGCTL + 32'(a), {$urandom, $urandom});
    for (int a = 0; a < 8; a++)
      msr(1'b0, MSR_DBGCTL + 32'(a), 64'h0);
    msr(1'b1, MSR_STATUS, '1);
    msr(1'b0, MSR_OVF_CLR, 64'h0);
    msr(1'b0, 32'h0000_0100, 64'h0);
    i_ce = 1'b0;
    i_msr_req = '{wr: 1'b1, rd: 1'b0, addr: MSR_DBGCTL, wdata: 64'h0};
    repeat (2) @(posedge i_clk_sys);
    #1;
    i_ce = 1'b1;
    msr(1'b0, MSR_DBGCTL, 64'h0);
    $display("test registers done");
    for (int c = 0; c < 16; c++)
    begin
      i_cpl = 2'(c);
      msr(1'b1, MSR_DBGCTL, 64'h00c1 | (64'(c >> 2) << DBG_OFF_PRIV_BIT));
    end
    $display("test filter done");
    for (int v = 0; v < 4; v++)
    begin
      i_perf_version = vers[v];
      for (int k = 0; k < 8; k++)
      begin
        i_cpl = 2'($urandom);
        msr(1'b1, MSR_DBGCTL, 64'h00c1 | (64'(k % 4) << DBG_FRZ_BR_BIT));
        msr(1'b1, MSR_GCTL, '1);
        msr(1'b1, MSR_FXCTL, 64'($urandom));
        msr(1'b1, MSR_EVTSEL_BASE + 32'(k % 4), 64'($urandom));
        fire(tfz_evt_s'($urandom));
        msr(1'b0, MSR_DBGCTL, 64'h0);
        msr(1'b0, MSR_GCTL, 64'h0);
        msr(1'b1, MSR_OVF_CLR, m_stat);
        msr(1'b0, MSR_STATUS, 64'h0);
      end
    end
    $display("test freeze done");
    print_verdict();
  end
endmodule

/* File: tfz_core.sv */
// trace filtering by privilege level and freeze of branch stack and counters on interrupt
`timescale 1ns/1ps
module tfz_core
  import tfz_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire tfz_msr_req_s i_msr_req,
  input wire tfz_evt_s i_evt,
  input wire logic [1:0] i_cpl,
  input wire logic [7:0] i_perf_version,
  output tfz_msr_rsp_s o_msr_rsp,
  output logic [31:0] o_leaf1_ecx,
  output logic o_branch_record_en,
  output logic o_trace_msg_en,
  output logic o_trace_store_en,
  output logic [NUM_GP-1:0] o_gp_count_en,
  output logic [NUM_FX-1:0] o_fx_count_en,
  output logic o_pmi_req
);
  logic [63:0] dbgctl_r, dbgctl_nxt;
  logic [63:0] gctl_r, gctl_nxt;
  logic [63:0] fxctl_r, fxctl_nxt;
  logic [63:0] evtsel_r [NUM_GP];
  logic [63:0] evtsel_nxt [NUM_GP];
  logic [63:0] status_r, status_nxt;
  tfz_msr_rsp_s rsp_r, rsp_nxt;
  logic [31:0] ecx_r, ecx_nxt;
  logic brec_r, brec_nxt;
  logic tmsg_r, tmsg_nxt;
  logic tstore_r, tstore_nxt;
  logic [NUM_GP-1:0] gpen_r, gpen_nxt;
  logic [NUM_FX-1:0] fxen_r, fxen_nxt;
  logic pmi_r, pmi_nxt;

  tfz_flavour_e flavour;
  logic pmi;
  logic suppress;
  logic sel_hit;
  logic [1:0] sel_idx;
  logic [31:0] sel_off;
  logic [NUM_GP-1:0] gp_pmi_en;
  logic [63:0] stat_set;
  logic dbg_wr;
  logic gctl_wr;
  logic clr_wr;

  always_comb
  begin
    if (i_perf_version >= VER_STREAM_MIN)
      flavour = FLV_STREAM;
    else if (i_perf_version >= VER_FREEZE_MIN)
      flavour = FLV_LEGACY;
    else
      flavour = FLV_NONE;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_GP; gi++)
    begin : g_sel
      assign gp_pmi_en[gi] = evtsel_r[gi][EVT_PMI_BIT];
    end
  endgenerate

  tfz_pmi_detect u_detect (
    .i_evt(i_evt),
    .i_gp_pmi_en(gp_pmi_en),
    .i_fxctl(fxctl_r),
    .o_pmi(pmi)
  );

  assign suppress = (i_cpl == 2'b00) ? dbgctl_nxt[DBG_OFF_PRIV_BIT] :
    dbgctl_nxt[DBG_OFF_USER_BIT];

  assign sel_off = i_msr_req.addr - MSR_EVTSEL_BASE;
  assign sel_hit = (i_msr_req.addr >= MSR_EVTSEL_BASE) &&
    (sel_off < 32'(NUM_GP));
  assign sel_idx = sel_off[1:0];
  assign dbg_wr = i_msr_req.wr && (i_msr_req.addr == MSR_DBGCTL);
  assign gctl_wr = i_msr_req.wr && (i_msr_req.addr == MSR_GCTL);
  assign clr_wr = i_msr_req.wr && (i_msr_req.addr == MSR_OVF_CLR);

  // overflow and threshold events that set status flags
  always_comb
  begin
    stat_set = '0;
    stat_set[NUM_GP-1:0] = i_evt.gp_ovf;
    stat_set[STAT_FX_LSB +: NUM_FX] = i_evt.fx_ovf;
    stat_set[STAT_BTS_BIT] = i_evt.bts_thresh;
    stat_set[STAT_PRECISE_SAMPLE_BUFFER_BIT] = i_evt.precise_sample_buffer_thresh;
    if (pmi && (flavour == FLV_STREAM))
    begin
      stat_set[STAT_BR_FRZ_BIT] = dbgctl_r[DBG_FRZ_BR_BIT];
      stat_set[STAT_COUNTER_FREEZE_FLAG_BIT] = dbgctl_r[DBG_FRZ_CTR_BIT];
    end
  end

  // register file and freeze next state
  always_comb
  begin
    dbgctl_nxt = dbgctl_r;
    gctl_nxt = gctl_r;
    fxctl_nxt = fxctl_r;
    evtsel_nxt = evtsel_r;
    status_nxt = status_r;
    rsp_nxt = '0;
    rsp_nxt.ack = i_msr_req.wr | i_msr_req.rd;
    if (i_msr_req.wr)
    begin
      if (i_msr_req.addr == MSR_DBGCTL)
        dbgctl_nxt = i_msr_req.wdata & DBG_WMASK;
      else if (i_msr_req.addr == MSR_GCTL)
        gctl_nxt = i_msr_req.wdata & GCTL_MASK;
      else if (i_msr_req.addr == MSR_FXCTL)
        fxctl_nxt = i_msr_req.wdata & FXCTL_MASK;
      else if (sel_hit)
        evtsel_nxt[sel_idx] = i_msr_req.wdata;
      else if (i_msr_req.addr == MSR_OVF_CLR)
        status_nxt = status_r & ~i_msr_req.wdata;
      else
        rsp_nxt.fault = 1'b1;
    end
    else if (i_msr_req.rd)
    begin
      if (i_msr_req.addr == MSR_DBGCTL)
        rsp_nxt.rdata = dbgctl_r;
      else if (i_msr_req.addr == MSR_GCTL)
        rsp_nxt.rdata = gctl_r;
      else if (i_msr_req.addr == MSR_FXCTL)
        rsp_nxt.rdata = fxctl_r;
      else if (sel_hit)
        rsp_nxt.rdata = evtsel_r[sel_idx];
      else if (i_msr_req.addr == MSR_STATUS)
        rsp_nxt.rdata = status_r;
      else if (i_msr_req.addr == MSR_OVF_CLR)
        rsp_nxt.rdata = '0;
      else
        rsp_nxt.fault = 1'b1;
    end
    status_nxt = status_nxt | stat_set;
    if (pmi && (flavour == FLV_LEGACY))
    begin
      if (dbgctl_r[DBG_FRZ_BR_BIT])
        dbgctl_nxt[DBG_REC_BIT] = 1'b0;
      if (dbgctl_r[DBG_FRZ_CTR_BIT])
        gctl_nxt = '0;
    end
  end

  // effective enables seen by the core
  always_comb
  begin
    ecx_nxt = CAP_LEAF1_ECX;
    brec_nxt = dbgctl_nxt[DBG_REC_BIT] & ~status_nxt[STAT_BR_FRZ_BIT];
    tmsg_nxt = dbgctl_nxt[DBG_MSG_BIT] & ~suppress;
    tstore_nxt = dbgctl_nxt[DBG_STORE_BIT] & ~suppress;
    gpen_nxt = gctl_nxt[NUM_GP-1:0] & {NUM_GP{~status_nxt[STAT_COUNTER_FREEZE_FLAG_BIT]}};
    fxen_nxt = gctl_nxt[GCTL_FX_LSB +: NUM_FX] & {NUM_FX{~status_nxt[STAT_COUNTER_FREEZE_FLAG_BIT]}};
    pmi_nxt = pmi;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      dbgctl_r <= RST_DBGCTL;
      gctl_r <= RST_GCTL;
      fxctl_r <= RST_FXCTL;
      for (int i = 0; i < NUM_GP; i++)
        evtsel_r[i] <= RST_EVTSEL;
      status_r <= RST_STATUS;
      rsp_r <= '0;
      ecx_r <= '0;
      brec_r <= 1'b0;
      tmsg_r <= 1'b0;
      tstore_r <= 1'b0;
      gpen_r <= '0;
      fxen_r <= '0;
      pmi_r <= 1'b0;
    end
    else if (i_ce)
    begin
      dbgctl_r <= dbgctl_nxt;
      gctl_r <= gctl_nxt;
      fxctl_r <= fxctl_nxt;
      evtsel_r <= evtsel_nxt;
      status_r <= status_nxt;
      rsp_r <= rsp_nxt;
      ecx_r <= ecx_nxt;
      brec_r <= brec_nxt;
      tmsg_r <= tmsg_nxt;
      tstore_r <= tstore_nxt;
      gpen_r <= gpen_nxt;
      fxen_r <= fxen_nxt;
      pmi_r <= pmi_nxt;
    end
  end

  assign o_msr_rsp = rsp_r;
  assign o_leaf1_ecx = ecx_r;
  assign o_branch_record_en = brec_r;
  assign o_trace_msg_en = tmsg_r;
  assign o_trace_store_en = tstore_r;
  assign o_gp_count_en = gpen_r;
  assign o_fx_count_en = fxen_r;
  assign o_pmi_req = pmi_r;

  // checks

  property p_cap;
    @(posedge i_clk_sys) disable iff (i_srst)
      $past(i_ce) && !$past(i_srst) |-> o_leaf1_ecx[CAP_CPL_TRACE_BIT];
  endproperty
  a_cap: assert property (p_cap) else $error("capability bit not reported");

  property p_supp_priv;
    @(posedge i_clk_sys) disable iff (i_srst)
      i_ce && (i_cpl == 2'b00) && dbgctl_nxt[DBG_OFF_PRIV_BIT]
      |=> !o_trace_msg_en && !o_trace_store_en;
  endproperty
  a_supp_priv: assert property (p_supp_priv) else $error("privileged trace not suppressed");

  property p_supp_user;
    @(posedge i_clk_sys) disable iff (i_srst)
      i_ce && (i_cpl != 2'b00) && dbgctl_nxt[DBG_OFF_USER_BIT]
      |=> !o_trace_msg_en && !o_trace_store_en;
  endproperty
  a_supp_user: assert property (p_supp_user) else $error("user trace not suppressed");

  property p_no_freeze;
    @(posedge i_clk_sys) disable iff (i_srst)
      i_ce && (flavour == FLV_NONE) && !dbg_wr && !gctl_wr && dbgctl_r[DBG_REC_BIT]
      && (gctl_r != '0) && !status_r[STAT_BR_FRZ_BIT]
      |=> dbgctl_r[DBG_REC_BIT] && (gctl_r != '0) && !status_r[STAT_BR_FRZ_BIT];
  endproperty
  a_no_freeze: assert property (p_no_freeze) else $error("freeze below version 2");

  property p_leg_branch;
    @(posedge i_clk_sys) disable iff (i_srst)
      i_ce && pmi && (flavour == FLV_LEGACY) && dbgctl_r[DBG_FRZ_BR_BIT]
      |=> !dbgctl_r[DBG_REC_BIT] && !o_branch_record_en && o_pmi_req;
  endproperty
  a_leg_branch: assert property (p_leg_branch) else $error("legacy branch freeze missed");

  property p_str_branch;
    @(posedge i_clk_sys) disable iff (i_srst)
      i_ce && pmi && (flavour == FLV_STREAM) && dbgctl_r[DBG_FRZ_BR_BIT] && !dbg_wr
      |=> status_r[STAT_BR_FRZ_BIT] && !o_branch_record_en &&
      (dbgctl_r[DBG_REC_BIT] == $past(dbgctl_r[DBG_REC_BIT]));
  endproperty
  a_str_branch: assert property (p_str_branch) else $error("streamlined branch freeze wrong");

  property p_leg_ctr;
    @(posedge i_clk_sys) disable iff (i_srst)
      i_ce && pmi && (flavour == FLV_LEGACY) && dbgctl_r[DBG_FRZ_CTR_BIT]
      |=> (gctl_r == '0) && (o_gp_count_en == '0) && (o_fx_count_en == '0);
  endproperty
  a_leg_ctr: assert property (p_leg_ctr) else $error("legacy counter freeze missed");

  property p_str_ctr;
    @(posedge i_clk_sys) disable iff (i_srst)
      i_ce && pmi && (flavour == FLV_STREAM) && dbgctl_r[DBG_FRZ_CTR_BIT] && !gctl_wr
      |=> status_r[STAT_COUNTER_FREEZE_FLAG_BIT] && (gctl_r == $past(gctl_r)) &&
      (o_gp_count_en == '0) && (o_fx_count_en == '0);
  endproperty
  a_str_ctr: assert property (p_str_ctr) else $error("streamlined counter freeze wrong");

  property p_pmi;
    @(posedge i_clk_sys) disable iff (i_srst)
      i_ce |=> (o_pmi_req == $past(pmi));
  endproperty
  a_pmi: assert property (p_pmi) else $error("interrupt request mismatch");

  property p_status_read;
    @(posedge i_clk_sys) disable iff (i_srst)
      i_ce && i_msr_req.rd && !i_msr_req.wr && (i_msr_req.addr == MSR_STATUS)
      |=> o_msr_rsp.ack && !o_msr_rsp.fault && (o_msr_rsp.rdata == $past(status_r));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_clear;
    @(posedge i_clk_sys) disable iff (i_srst)
      i_ce && clr_wr && !pmi && (stat_set == '0)
      |=> ((status_r & $past(i_msr_req.wdata)) == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("status flags not cleared");

  property p_hold;
    @(posedge i_clk_sys) disable iff (i_srst)
      status_r[STAT_COUNTER_FREEZE_FLAG_BIT] && !(clr_wr && i_msr_req.wdata[STAT_COUNTER_FREEZE_FLAG_BIT])
      |=> status_r[STAT_COUNTER_FREEZE_FLAG_BIT];
  endproperty
  a_hold: assert property (p_hold) else $error("counter freeze flag dropped");
endmodule

/* File: tfz_pkg.sv */
// constants, types and field layout for the trace filter and interrupt freeze block
// How it works
// - capability bit 4 reports privilege-qualified tracing
// - debug control bits 10/9 suppress user/privileged
// - privileged suppress at level 0, user above
// - freeze controls only from monitor version 2
// - debug control bit 11 enables branch freezing
// - legacy freeze clears branch recording enable bit
// - streamlined freeze sets branch flag, keeps enable
// - debug control bit 12 enables counter freezing
// - legacy counter freeze clears global counter enable
// - streamlined counter freeze sets flag, keeps enable
// - freeze on overflow of interrupt-enabled counter
// - event select bit 20 enables counter interrupt
// - fixed field bit 3 enables interrupt
// - buffer thresholds also trigger the freezes
// - overflow status readable at 0x38e
// - writing ones at 0x390 clears status
package tfz_pkg;
  localparam int NUM_GP = 4;
  localparam int NUM_FX = 3;
  localparam int FX_FIELD_W = 4;
  localparam int FX_PMI_BIT = 3;
  localparam int EVT_PMI_BIT = 20;

  localparam logic [31:0] MSR_STATUS = 32'h0000038e;
  localparam logic [31:0] MSR_OVF_CLR = 32'h00000390;
  localparam logic [31:0] MSR_DBGCTL = 32'h00000c00;
  localparam logic [31:0] MSR_GCTL = 32'h00000c01;
  localparam logic [31:0] MSR_FXCTL = 32'h00000c02;
  localparam logic [31:0] MSR_EVTSEL_BASE = 32'h00000c04;

  localparam int DBG_REC_BIT = 0;
  localparam int DBG_MSG_BIT = 6;
  localparam int DBG_STORE_BIT = 7;
  localparam int DBG_OFF_PRIV_BIT = 9;
  localparam int DBG_OFF_USER_BIT = 10;
  localparam int DBG_FRZ_BR_BIT = 11;
  localparam int DBG_FRZ_CTR_BIT = 12;
  localparam logic [63:0] DBG_WMASK = 64'h0000_0000_0000_dfc3;
  localparam logic [63:0] GCTL_MASK = 64'h0000_0007_0000_000f;
  localparam logic [63:0] FXCTL_MASK = 64'h0000_0000_0000_0fff;
  localparam int GCTL_FX_LSB = 32;

  localparam int STAT_FX_LSB = 32;
  localparam int STAT_BTS_BIT = 61;
  localparam int STAT_PRECISE_SAMPLE_BUFFER_BIT = 62;
  localparam int STAT_BR_FRZ_BIT = 58;
  localparam int STAT_COUNTER_FREEZE_FLAG_BIT = 59;

  localparam logic [63:0] RST_DBGCTL = 64'h0;
  localparam logic [63:0] RST_GCTL = 64'h0;
  localparam logic [63:0] RST_FXCTL = 64'h0;
  localparam logic [63:0] RST_EVTSEL = 64'h0;
  localparam logic [63:0] RST_STATUS = 64'h0;

  localparam logic [7:0] VER_FREEZE_MIN = 8'h02;
  localparam logic [7:0] VER_STREAM_MIN = 8'h04;
  localparam int CAP_CPL_TRACE_BIT = 4;
  localparam logic [31:0] CAP_LEAF1_ECX = 32'h0000_0010;

  typedef enum logic [1:0] {
    FLV_NONE = 2'b00,
    FLV_LEGACY = 2'b01,
    FLV_STREAM = 2'b11
  } tfz_flavour_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [31:0] addr;
    logic [63:0] wdata;
  } tfz_msr_req_s;

  typedef struct packed {
    logic ack;
    logic fault;
    logic [63:0] rdata;
  } tfz_msr_rsp_s;

  typedef struct packed {
    logic [NUM_GP-1:0] gp_ovf;
    logic [NUM_FX-1:0] fx_ovf;
    logic precise_sample_buffer_thresh;
    logic bts_thresh;
  } tfz_evt_s;
endpackage

/* File: tfz_pmi_detect.sv */
// interrupt-condition detection from counter overflows and buffer thresholds
`timescale 1ns/1ps
module tfz_pmi_detect
  import tfz_pkg::*;
(
  input wire tfz_evt_s i_evt,
  input wire logic [NUM_GP-1:0] i_gp_pmi_en,
  input wire logic [63:0] i_fxctl,
  output logic o_pmi
);
  logic [NUM_GP-1:0] gp_hit;
  logic [NUM_FX-1:0] fx_hit;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_GP + NUM_FX; gi++)
    begin : g_hit
      if (gi < NUM_GP)
      begin : g_gp
        assign gp_hit[gi] = i_evt.gp_ovf[gi] & i_gp_pmi_en[gi];
      end
      else
      begin : g_fx
        assign fx_hit[gi-NUM_GP] = i_evt.fx_ovf[gi-NUM_GP] &
          i_fxctl[(gi-NUM_GP)*FX_FIELD_W+FX_PMI_BIT];
      end
    end
  endgenerate

  assign o_pmi = (|gp_hit) | (|fx_hit) | i_evt.precise_sample_buffer_thresh | i_evt.bts_thresh;
endmodule
